//--- rtl/tpwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer pair
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH
`define TPWM_OFF_RUN        12'h000
`define TPWM_OFF_MODE       12'h004
`define TPWM_OFF_LCMP       12'h008
`define TPWM_OFF_UCMP       12'h00c
`define TPWM_OFF_FFCR       12'h010
`define TPWM_OFF_STAT       12'h014
`define TPWM_RUN_LOWER      0
`define TPWM_RUN_UPPER      1
`define TPWM_RUN_PRESCALE   7
`define TPWM_MODE_LCLK_LSB  0
`define TPWM_MODE_UCLK_LSB  2
`define TPWM_MODE_CYC_LSB   4
`define TPWM_MODE_PAIR_LSB  6
`define TPWM_FF_SRC         0
`define TPWM_FF_CTL_LSB     1
`define TPWM_FF_INV_EN      3
`define TPWM_FF_DBUF_EN     4
`define TPWM_FF_CLEAR       2'h1
`define TPWM_FF_SET         2'h0
`define TPWM_RST_BYTE       8'h00
`define TPWM_DIV_FINE       8
`endif

//--- rtl/tpwm_pkg.sv
// Types of the timer pair with PWM mode
package tpwm_pkg;
    typedef enum logic [1:0] {
        TPWM_PAIR_TWO8,
        TPWM_PAIR_CAS16,
        TPWM_PAIR_PPG,
        TPWM_PAIR_PWM
    } tpwm_pair_t;
endpackage

//--- rtl/tpwm_top.sv
// Dual 8-bit timer pair with 8-bit PWM mode and APB register slave
//
// Behaviour
// - PWM runs only on the lower timer, resolution up to 8 bits.
// - PWM waveform from lower timer drives the pair output pin.
// - Upper timer still works as independent 8-bit interval timer during PWM.
// - Output flip-flop toggles on compare match and on 2^n overflow.
// - Lower counter clears to zero at each 2^n overflow in PWM.
// - With double buffer on, buffer loads compare register at 2^n overflow.
// - Pair mode 00 two timers, 01 cascade, 10 PPG, 11 PWM; here 01 and 10 have no cascade or PPG logic, the flip-flop never toggles.
// - Cycle select 01, 10, 11 gives 2^6, 2^7, 2^8 periods.
// - Two-timer mode: source bit picks lower or upper match to toggle.
// - In mode 11 upper timer uses taps 01/10/11, its flip-flop output off.
// - Clearing run bit stops lower timer, clears counter; software restarts it.
// - One control write clears flip-flop, enables inversion and double buffer.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tpwm_consts.svh"

module tpwm_top
    import tpwm_pkg::*;
#(
    parameter int PRESCALE_BITS = 10
) (
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        LOWER_EXT_CLK,
    output logic             PAIR_OUTPUT_PIN
);

    ////////////////////////////////////////////////////////////////////////////
    // Taps reach bit 9, so a shorter prescaler cannot serve the upper timer
    if (PRESCALE_BITS < 10 || PRESCALE_BITS > 16) begin : g_bad_prescale
        $error("PRESCALE_BITS must lie in 10..16");
    end

    typedef struct packed {
        logic [PRESCALE_BITS-1:0] presc;
        logic                     ext_s1;
        logic                     ext_s2;
        logic                     ext_s3;
        logic                     run_lower;
        logic                     run_upper;
        logic                     run_presc;
        logic [1:0]               lower_clock_select;
        logic [1:0]               upper_clock_select;
        logic [1:0]               pwm_cycle_select;
        tpwm_pair_t               pair_mode_select;
        logic [7:0]               lower_compare_reg;
        logic [7:0]               lower_buffer;
        logic [7:0]               upper_compare_reg;
        logic [7:0]               lower_up_counter;
        logic [7:0]               upper_counter;
        logic                     flipflop_source_select;
        logic                     inv_en;
        logic                     dbuf_en;
        logic                     output_flipflop;
        logic                     pin;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
    } tpwm_state_t;

    tpwm_state_t s_q;
    tpwm_state_t s_d;

    logic                     lower_tick;
    logic                     upper_tick;
    logic                     lower_match;
    logic                     upper_match;
    logic                     ovf;
    logic [8:0]               period;
    logic                     toggle;
    logic                     wr;
    logic                     rd;
    logic [PRESCALE_BITS-1:0] presc_nx;

    ////////////////////////////////////////////////////////////////////////////
    // Tap pulses: one-cycle enables on a bit rising out of the prescaler
    function automatic logic tap(input logic [PRESCALE_BITS-1:0] o,
                                 input logic [PRESCALE_BITS-1:0] n, input int b);
        return !o[b] && n[b];
    endfunction

    always_comb begin
        presc_nx = s_q.run_presc ? s_q.presc + 1'b1 : s_q.presc;
        case (s_q.lower_clock_select)
            2'h0:    lower_tick = s_q.ext_s2 && !s_q.ext_s3;
            2'h1:    lower_tick = tap(s_q.presc, presc_nx, 2);
            2'h2:    lower_tick = tap(s_q.presc, presc_nx, 4);
            default: lower_tick = tap(s_q.presc, presc_nx, 6);
        endcase
        lower_tick = lower_tick && s_q.run_lower;
        // Upper timer clocking; mode 11 cannot use lower match
        case (s_q.upper_clock_select)
            // Count match events, not cycles spent at the match value
            2'h0:    upper_tick = (s_q.pair_mode_select == TPWM_PAIR_TWO8)
                                  && lower_tick && lower_match;
            2'h1:    upper_tick = tap(s_q.presc, presc_nx, 2);
            2'h2:    upper_tick = tap(s_q.presc, presc_nx, 6);
            default: upper_tick = tap(s_q.presc, presc_nx, 9);
        endcase
        upper_tick = upper_tick && s_q.run_upper;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Cycle select decode
        case (s_q.pwm_cycle_select)
            2'h1:    period = 9'h040;
            2'h2:    period = 9'h080;
            default: period = 9'h100;
        endcase
        lower_match = s_q.lower_up_counter == s_q.lower_compare_reg;
        upper_match = s_q.upper_counter == s_q.upper_compare_reg;
        ovf = (s_q.pair_mode_select == TPWM_PAIR_PWM) && lower_tick
            && ({1'b0, s_q.lower_up_counter} == period - 9'h001);
        // Mode decode selects what toggles the flip-flop
        case (s_q.pair_mode_select)
            TPWM_PAIR_TWO8:  toggle = s_q.flipflop_source_select
                                    ? (upper_tick && upper_match)
                                    : (lower_tick && lower_match);
            TPWM_PAIR_CAS16: toggle = 1'b0;
            TPWM_PAIR_PPG:   toggle = 1'b0;
            TPWM_PAIR_PWM:   toggle = (lower_tick && lower_match) || ovf;
            default:         toggle = 1'b0;
        endcase
        wr = PSEL && PENABLE && PWRITE && !s_q.pready;
        rd = PSEL && PENABLE && !PWRITE && !s_q.pready;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d         = s_q;
        s_d.presc   = presc_nx;
        s_d.ext_s1  = LOWER_EXT_CLK;
        s_d.ext_s2  = s_q.ext_s1;
        s_d.ext_s3  = s_q.ext_s2;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (!s_q.run_presc) begin
            s_d.presc = '0;
        end

        // Lower counter; overflow clears it in PWM
        if (!s_q.run_lower) begin
            s_d.lower_up_counter = `TPWM_RST_BYTE;
        end else if (ovf) begin
            s_d.lower_up_counter = `TPWM_RST_BYTE;
        end else if (lower_tick) begin
            if (s_q.pair_mode_select == TPWM_PAIR_TWO8 && lower_match) begin
                s_d.lower_up_counter = `TPWM_RST_BYTE;
            end else begin
                s_d.lower_up_counter = s_q.lower_up_counter + 8'h01;
            end
        end
        // Double buffer transfer on overflow
        if (ovf && s_q.dbuf_en) begin
            s_d.lower_compare_reg = s_q.lower_buffer;
        end

        if (!s_q.run_upper) begin
            s_d.upper_counter = `TPWM_RST_BYTE;
        end else if (upper_tick) begin
            s_d.upper_counter = upper_match ? `TPWM_RST_BYTE : s_q.upper_counter + 8'h01;
        end

        if (toggle && s_q.inv_en) begin
            s_d.output_flipflop = !s_q.output_flipflop;
        end
        // Pin follows lower-timer flip-flop in PWM
        s_d.pin = s_q.output_flipflop;

        if (wr) begin
            s_d.pready = 1'b1;
            case (PADDR)
                `TPWM_OFF_RUN: begin
                    s_d.run_lower = PWDATA[`TPWM_RUN_LOWER];
                    s_d.run_upper = PWDATA[`TPWM_RUN_UPPER];
                    s_d.run_presc = PWDATA[`TPWM_RUN_PRESCALE];
                end
                `TPWM_OFF_MODE: begin
                    s_d.lower_clock_select = PWDATA[`TPWM_MODE_LCLK_LSB +: 2];
                    s_d.upper_clock_select = PWDATA[`TPWM_MODE_UCLK_LSB +: 2];
                    s_d.pwm_cycle_select   = PWDATA[`TPWM_MODE_CYC_LSB +: 2];
                    s_d.pair_mode_select   = tpwm_pair_t'(PWDATA[`TPWM_MODE_PAIR_LSB +: 2]);
                end
                `TPWM_OFF_LCMP: begin
                    // Buffered write lands at next overflow only
                    s_d.lower_buffer = PWDATA[7:0];
                    if (!s_q.dbuf_en || s_q.pair_mode_select != TPWM_PAIR_PWM) begin
                        s_d.lower_compare_reg = PWDATA[7:0];
                    end
                end
                `TPWM_OFF_UCMP: s_d.upper_compare_reg = PWDATA[7:0];
                `TPWM_OFF_FFCR: begin
                    // Single write: clear, inversion and buffer together
                    s_d.flipflop_source_select = PWDATA[`TPWM_FF_SRC];
                    s_d.inv_en  = PWDATA[`TPWM_FF_INV_EN];
                    s_d.dbuf_en = PWDATA[`TPWM_FF_DBUF_EN];
                    if (PWDATA[`TPWM_FF_CTL_LSB +: 2] == `TPWM_FF_CLEAR) begin
                        s_d.output_flipflop = 1'b0;
                    end else if (PWDATA[`TPWM_FF_CTL_LSB +: 2] == `TPWM_FF_SET) begin
                        s_d.output_flipflop = 1'b1;
                    end
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end

        if (rd) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
            case (PADDR)
                `TPWM_OFF_RUN:  s_d.prdata = {24'h0, s_q.run_presc, 5'h0,
                                               s_q.run_upper, s_q.run_lower};
                `TPWM_OFF_MODE: s_d.prdata = {24'h0, s_q.pair_mode_select,
                                               s_q.pwm_cycle_select, s_q.upper_clock_select,
                                               s_q.lower_clock_select};
                `TPWM_OFF_LCMP: s_d.prdata = {24'h0, s_q.lower_compare_reg};
                `TPWM_OFF_UCMP: s_d.prdata = {24'h0, s_q.upper_compare_reg};
                `TPWM_OFF_FFCR: s_d.prdata = {27'h0, s_q.dbuf_en, s_q.inv_en, 2'h0,
                                               s_q.flipflop_source_select};
                // Live state, read-only
                `TPWM_OFF_STAT: s_d.prdata = {15'h0, s_q.output_flipflop,
                                               s_q.upper_counter, s_q.lower_up_counter};
                default:        s_d.pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA          = s_q.prdata;
    assign PREADY          = s_q.pready;
    assign PSLVERR         = s_q.pslverr;
    assign PAIR_OUTPUT_PIN = s_q.pin;

    ////////////////////////////////////////////////////////////////////////////
    AST_OVF_CLEARS: assert property (@(posedge CLOCK) disable iff (!NRST)
        ovf && !(wr && PADDR == `TPWM_OFF_RUN) |=> s_q.lower_up_counter == 8'h00)
        else $error("counter not cleared at overflow");
    AST_STOP_CLEARS: assert property (@(posedge CLOCK) disable iff (!NRST)
        !s_q.run_lower |=> s_q.lower_up_counter == 8'h00)
        else $error("stopped counter not zero");
    AST_DBUF_LOAD: assert property (@(posedge CLOCK) disable iff (!NRST)
        ovf && s_q.dbuf_en && !wr |=> s_q.lower_compare_reg == $past(s_q.lower_buffer))
        else $error("buffer not transferred");
    AST_PWM_TOGGLE: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_PWM && s_q.inv_en && ovf && !wr
        |=> s_q.output_flipflop != $past(s_q.output_flipflop))
        else $error("no toggle at overflow");
    AST_PIN_FOLLOW: assert property (@(posedge CLOCK) disable iff (!NRST)
        ##1 PAIR_OUTPUT_PIN == $past(s_q.output_flipflop))
        else $error("pin does not follow flip-flop");
    AST_PERIOD_MAX: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_PWM && s_q.pwm_cycle_select == 2'h1
        && s_q.lower_up_counter < 8'h40 && !wr |=> s_q.lower_up_counter < 8'h40)
        else $error("counter passed 2^6 period");
    AST_UPPER_RUNS: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_PWM && upper_tick && !upper_match && !wr
        |=> s_q.upper_counter == $past(s_q.upper_counter) + 8'h01)
        else $error("upper timer stalled in PWM mode");
    AST_UPPER_NO_FF: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_PWM && !ovf && !(lower_tick && lower_match) && !wr
        |=> s_q.output_flipflop == $past(s_q.output_flipflop))
        else $error("flip-flop moved by upper timer");
    AST_SRC_SEL: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_TWO8 && s_q.flipflop_source_select
        && lower_tick && lower_match && !(upper_tick && upper_match) && !wr
        |=> $stable(s_q.output_flipflop))
        else $error("lower match toggled with upper source");
    AST_FFCR_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
        wr && PADDR == `TPWM_OFF_FFCR && PWDATA[4:1] == 4'hd
        |=> !s_q.output_flipflop && s_q.inv_en && s_q.dbuf_en)
        else $error("flip-flop control write not applied");

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and register checks

    AST_PREADY_PULSE: assert property (@(posedge CLOCK) disable iff (!NRST)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    AST_PREADY_ANSWER: assert property (@(posedge CLOCK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access not answered after one wait state");

    AST_SLVERR_WITH_READY: assert property (@(posedge CLOCK) disable iff (!NRST)
        PSLVERR |-> PREADY)
        else $error("error without ready");

    AST_UNMAPPED_ERR: assert property (@(posedge CLOCK) disable iff (!NRST)
        PSEL && PENABLE && !PREADY && PADDR > `TPWM_OFF_STAT
        |=> PSLVERR)
        else $error("unmapped access without error");

    AST_RUN_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
        wr && PADDR == `TPWM_OFF_RUN |=> s_q.run_lower == $past(PWDATA[0]))
        else $error("run bit write lost");

    AST_MODE_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
        wr && PADDR == `TPWM_OFF_MODE
        |=> 2'(s_q.pair_mode_select) == $past(PWDATA[7:6]))
        else $error("pair mode write lost");

    AST_LCMP_DIRECT: assert property (@(posedge CLOCK) disable iff (!NRST)
        wr && PADDR == `TPWM_OFF_LCMP && !s_q.dbuf_en
        |=> s_q.lower_compare_reg == $past(PWDATA[7:0]))
        else $error("unbuffered compare write lost");

    AST_LCMP_HELD: assert property (@(posedge CLOCK) disable iff (!NRST)
        wr && PADDR == `TPWM_OFF_LCMP && s_q.dbuf_en
        && s_q.pair_mode_select == TPWM_PAIR_PWM && !ovf
        |=> $stable(s_q.lower_compare_reg))
        else $error("buffered compare applied early");

    AST_INV_OFF_HOLD: assert property (@(posedge CLOCK) disable iff (!NRST)
        !s_q.inv_en && !wr |=> $stable(s_q.output_flipflop))
        else $error("flip-flop toggled with inversion off");

    AST_UPPER_STOP: assert property (@(posedge CLOCK) disable iff (!NRST)
        !s_q.run_upper |=> s_q.upper_counter == 8'h00)
        else $error("stopped upper counter not zero");

    AST_TWO8_CLEAR: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_TWO8 && lower_tick && lower_match && !wr
        |=> s_q.lower_up_counter == 8'h00)
        else $error("lower counter not cleared at match");

    AST_PERIOD_7: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_q.pair_mode_select == TPWM_PAIR_PWM && s_q.pwm_cycle_select == 2'h2
        && s_q.lower_up_counter < 8'h80 && !wr
        |=> s_q.lower_up_counter < 8'h80)
        else $error("counter passed 2^7 period");

endmodule

//--- dv/tpwm_top_tb.sv
// Self-checking bench for the timer pair: register access, PWM, two-timer modes
`timescale 1ns/1ps
`include "tpwm_consts.svh"

module tpwm_top_tb
    import tpwm_pkg::*;
;
    localparam logic [11:0] ORUN = `TPWM_OFF_RUN, OMOD = `TPWM_OFF_MODE, OLC = `TPWM_OFF_LCMP;
    localparam logic [11:0] OUC = `TPWM_OFF_UCMP, OFF = `TPWM_OFF_FFCR, OST = `TPWM_OFF_STAT;
    localparam logic [1:0]  PWM = 2'(TPWM_PAIR_PWM);

    logic        clock;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lower_ext_clk;
    logic        pair_output_pin;
    logic [31:0] rd;
    logic        err;
    int          n_errors;
    int          cmp_count;

    ////////////////////////////////////////////////////////////////////////////////////////
    tpwm_top #(.PRESCALE_BITS(10)) tpwm_top_inst (
        .CLOCK           (clock),
        .NRST            (nrst),
        .PSEL            (psel),
        .PENABLE         (penable),
        .PWRITE          (pwrite),
        .PADDR           (paddr),
        .PWDATA          (pwdata),
        .PRDATA          (prdata),
        .PREADY          (pready),
        .PSLVERR         (pslverr),
        .LOWER_EXT_CLK   (lower_ext_clk),
        .PAIR_OUTPUT_PIN (pair_output_pin)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_errors++;
            $display("[FAIL] pready expected 1 seen 0");
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(what, exp, rd);
    endtask

    // Slow external edges so the two-stage synchroniser never drops one
    task automatic ticks(input int n);
        repeat (n) begin
            lower_ext_clk <= 1'b1;
            repeat (3) @(posedge clock);
            lower_ext_clk <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] m;
        {nrst, psel, penable, pwrite, lower_ext_clk} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rdchk("status reset", OST, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk_word("unmapped data", 32'h0, rd);
        chk_bit("unmapped err", 1'b1, err);
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(OMOD, {24'h0, m, m, m, m});
            rdchk("mode field", OMOD, {24'h0, m, m, m, m});
        end
        $display("test registers done");
        // PWM, n = 6, compare 0x20, external count clock
        wr(ORUN, 32'h0);
        wr(OMOD, {24'h0, PWM, 2'h1, 4'h0});
        wr(OLC, 32'h20);
        wr(OFF, 32'h1a);
        rdchk("ff cleared", OST, 32'h0);
        wr(ORUN, 32'h1);
        ticks(32);
        rdchk("before match", OST, 32'h20);
        ticks(1);
        rdchk("after match", OST, 32'h10021);
        chk_bit("pin high", 1'b1, pair_output_pin);
        ticks(31);
        rdchk("overflow", OST, 32'h0);
        chk_bit("pin low", 1'b0, pair_output_pin);
        // Buffered compare must not act before the next boundary
        wr(OLC, 32'h10);
        ticks(17);
        rdchk("buffer held", OST, 32'h11);
        ticks(16);
        rdchk("old compare", OST, 32'h10021);
        ticks(48);
        rdchk("new compare", OST, 32'h10011);
        wr(ORUN, 32'h0);
        ticks(5);
        apb(1'b0, OST, 32'h0);
        chk_word("stopped count", 32'h0, rd & 32'hff);
        wr(ORUN, 32'h1);
        ticks(2);
        apb(1'b0, OST, 32'h0);
        chk_word("restart count", 32'h2, rd & 32'hff);
        $display("test pwm done");
        // Upper timer alone in mode 11, fine tap
        wr(ORUN, 32'h0);
        wr(OFF, 32'h0b);
        wr(OUC, 32'hff);
        wr(OMOD, {24'h0, PWM, 2'h1, 2'h1, 2'h0});
        wr(ORUN, 32'h82);
        repeat (200) @(posedge clock);
        apb(1'b0, OST, 32'h0);
        chk_bit("upper counts", 1'b1, rd[15:8] != 8'h00);
        wr(ORUN, 32'h80);
        wr(OUC, 32'h3);
        wr(ORUN, 32'h82);
        repeat (200) @(posedge clock);
        apb(1'b0, OST, 32'h0);
        chk_bit("upper ff off", 1'b0, rd[16]);
        chk_bit("upper pin off", 1'b0, pair_output_pin);
        $display("test upper done");
        // Two timers: three ticks give exactly one lower match
        for (int s = 0; s < 2; s++) begin
            wr(ORUN, 32'h0);
            wr(OMOD, 32'h0);
            wr(OLC, 32'h2);
            wr(OUC, 32'h7);
            wr(OFF, 32'h0a | 32'(s));
            wr(ORUN, 32'h3);
            ticks(3);
            apb(1'b0, OST, 32'h0);
            chk_bit("source select ff", s == 0, rd[16]);
        end
        $display("test two timers done");
        report_and_stop();
    end
endmodule
